// >>> pkg/oag_pkg.sv
package oag_pkg;

    // ==========================================================
    // Addressing modes
    typedef enum logic [2:0] {
        OAG_MODE_REG,
        OAG_MODE_IND_REG,
        OAG_MODE_INDEXED,
        OAG_MODE_DIRECT,
        OAG_MODE_IND_ADDR,
        OAG_MODE_RELATIVE,
        OAG_MODE_IMMEDIATE,
        OAG_MODE_STACK
    } oag_mode_e;

    // ==========================================================
    // Target spaces
    typedef enum logic [1:0] {
        OAG_SPACE_REGFILE,
        OAG_SPACE_PROGMEM,
        OAG_SPACE_EXTMEM,
        OAG_SPACE_NONE
    } oag_space_e;

    // ==========================================================
    // Instruction classes that restrict modes
    typedef enum logic [2:0] {
        OAG_CLS_GENERAL_LOAD,
        OAG_CLS_PROGMEM_LOAD,
        OAG_CLS_EXTDATA_LOAD,
        OAG_CLS_CALL,
        OAG_CLS_JUMP,
        OAG_CLS_REL_BRANCH,
        OAG_CLS_OTHER
    } oag_class_e;

    // ==========================================================
    // Field layout and constants
    localparam logic [3:0] OAG_WREG_PREFIX = 4'h000c;
    localparam int OAG_WIN_BIT = 3;
    localparam logic [7:0] OAG_SET1_BASE = 8'h00c0;
    localparam logic [1:0] OAG_SET1_HI = 2'h0003;
    localparam logic [7:0] OAG_ZERO_BYTE = 8'h0000;
    localparam logic [15:0] OAG_ZERO_WORD = 16'h0000;
    localparam logic [7:0] OAG_ONE_BYTE = 8'h0001;
    localparam logic [7:0] OAG_SP_RESET = 8'h00ff;
    localparam logic [7:0] OAG_WIN0_RESET = 8'h00c0;
    localparam logic [7:0] OAG_WIN1_RESET = 8'h00c8;

endpackage

// >>> rtl/oag_top.sv
`timescale 1ns/100ps

// Operation
// - Eight addressing modes; each instruction class accepts only some.
// - Register mode: operand is the named register or pair.
// - Working registers: window pointer selects 8-byte slice, instruction picks register.
// - Indirect register: register content is the operand address.
// - Any byte register points into register file; pairs into memory.
// - Indirect register access never reaches set-1 locations C0-FF.
// - Indexed access never reaches set-1 locations C0-FF.
// - Short indexed offset is sign-extended, memory index only.
// - Register-file index: instruction base plus working-register offset.
// - Memory index: working pair base plus 8- or 16-bit offset.
// - Only general load indexes register file; memory loads index memory.
// - Direct mode carries 16-bit address; jump and call load it to PC.
// - Memory loads accept direct address as source or destination.
// - Indirect address mode reads vector in lowest 256 bytes; call only.
// - Indirect address pointer is 8 bits with upper bits zero.
// - Relative: signed displacement added to PC of following instruction.
// - Relative mode used by bit-test, decrement, compare and short jumps.
// - Immediate operand comes from the instruction field, byte or word.
// - Push pre-decrements stack address; pop post-increments it.
// - 4-bit address: top bit picks window pointer, 5+3 bits concatenated.
module oag_top (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic req_valid,
    input wire oag_pkg::oag_mode_e mode,
    input wire oag_pkg::oag_class_e instr_class,
    input wire logic [7:0] reg_field,
    input wire logic pair_sel,
    input wire logic short_offset,
    input wire logic word_operand,
    input wire logic [15:0] operand_field,
    input wire logic [15:0] pc_next,
    input wire logic [15:0] reg_value,
    input wire logic push_req,
    input wire logic pop_req,
    input wire logic [7:0] first_window_pointer,
    input wire logic [7:0] second_window_pointer,
    input wire logic [7:0] page_select_reg,
    output logic [7:0] reg_addr_r,
    output logic [15:0] eff_addr_r,
    output oag_pkg::oag_space_e space_r,
    output logic [15:0] operand_r,
    output logic operand_valid_r,
    output logic pc_load_r,
    output logic vector_fetch_r,
    output logic illegal_r,
    output logic done_r,
    output logic [7:0] stack_pointer_low_byte,
    output logic [7:0] stack_addr_r
);

    // ==========================================================
    // Register address forming
    // Both 4-bit and 1100b-prefixed 8-bit forms use the window
    logic is_wreg;
    logic [7:0] win_ptr;
    logic [7:0] named_addr;
    assign is_wreg = (reg_field[7:4] == oag_pkg::OAG_WREG_PREFIX);
    assign win_ptr = reg_field[oag_pkg::OAG_WIN_BIT] ? second_window_pointer
                                                     : first_window_pointer;
    assign named_addr = is_wreg ? {win_ptr[7:3], reg_field[2:0]} : reg_field;

    // ==========================================================
    // Indirect and indexed effective addresses
    logic [7:0] ind_reg_addr;
    logic [7:0] idx_reg_addr;
    logic [15:0] short_ext;
    logic [15:0] idx_mem_addr;
    logic set1_hit_ind;
    logic set1_hit_idx;
    assign ind_reg_addr = reg_value[7:0];
    assign idx_reg_addr = operand_field[7:0] + reg_value[7:0];
    assign short_ext = {{8{operand_field[7]}}, operand_field[7:0]};
    assign idx_mem_addr = reg_value + (short_offset ? short_ext : operand_field);
    // Set-1 upper block is only reachable by register names and by stack accesses
    assign set1_hit_ind = (ind_reg_addr[7:6] == oag_pkg::OAG_SET1_HI);
    assign set1_hit_idx = (idx_reg_addr[7:6] == oag_pkg::OAG_SET1_HI);

    // ==========================================================
    // Relative, indirect-address and class permission
    logic [15:0] rel_target;
    logic [15:0] vec_addr;
    logic mem_load;
    logic mem_space_ext;
    assign rel_target = pc_next + {{8{operand_field[7]}}, operand_field[7:0]};
    assign vec_addr = {oag_pkg::OAG_ZERO_BYTE, operand_field[7:0]};
    assign mem_load = (instr_class == oag_pkg::OAG_CLS_PROGMEM_LOAD) ||
                      (instr_class == oag_pkg::OAG_CLS_EXTDATA_LOAD);
    assign mem_space_ext = (instr_class == oag_pkg::OAG_CLS_EXTDATA_LOAD);

    // ==========================================================
    // Stack pointer arithmetic
    logic [7:0] sp_dec;
    logic [7:0] sp_inc;
    assign sp_dec = stack_pointer_low_byte - oag_pkg::OAG_ONE_BYTE;
    assign sp_inc = stack_pointer_low_byte + oag_pkg::OAG_ONE_BYTE;

    // ==========================================================
    // Mode decode into next-state values
    logic [7:0] reg_addr_nxt;
    logic [15:0] eff_addr_nxt;
    oag_pkg::oag_space_e space_nxt;
    logic [15:0] operand_nxt;
    logic operand_valid_nxt;
    logic pc_load_nxt;
    logic vector_fetch_nxt;
    logic illegal_nxt;
    always_comb begin
        reg_addr_nxt = oag_pkg::OAG_ZERO_BYTE;
        eff_addr_nxt = oag_pkg::OAG_ZERO_WORD;
        space_nxt = oag_pkg::OAG_SPACE_NONE;
        operand_nxt = oag_pkg::OAG_ZERO_WORD;
        operand_valid_nxt = 1'b0;
        pc_load_nxt = 1'b0;
        vector_fetch_nxt = 1'b0;
        illegal_nxt = 1'b0;
        case (mode)
            oag_pkg::OAG_MODE_REG: begin
                reg_addr_nxt = named_addr;
                eff_addr_nxt = {oag_pkg::OAG_ZERO_BYTE, named_addr};
                space_nxt = oag_pkg::OAG_SPACE_REGFILE;
                operand_nxt = pair_sel ? reg_value
                                       : {oag_pkg::OAG_ZERO_BYTE, reg_value[7:0]};
                operand_valid_nxt = 1'b1;
            end
            oag_pkg::OAG_MODE_IND_REG: begin
                reg_addr_nxt = named_addr;
                if (mem_load) begin
                    eff_addr_nxt = reg_value;
                    space_nxt = mem_space_ext ? oag_pkg::OAG_SPACE_EXTMEM
                                              : oag_pkg::OAG_SPACE_PROGMEM;
                end else if (set1_hit_ind) begin
                    illegal_nxt = 1'b1;
                end else begin
                    eff_addr_nxt = {oag_pkg::OAG_ZERO_BYTE, ind_reg_addr};
                    space_nxt = oag_pkg::OAG_SPACE_REGFILE;
                end
            end
            oag_pkg::OAG_MODE_INDEXED: begin
                reg_addr_nxt = named_addr;
                if (mem_load) begin
                    eff_addr_nxt = idx_mem_addr;
                    space_nxt = mem_space_ext ? oag_pkg::OAG_SPACE_EXTMEM
                                              : oag_pkg::OAG_SPACE_PROGMEM;
                end else if (instr_class != oag_pkg::OAG_CLS_GENERAL_LOAD) begin
                    illegal_nxt = 1'b1;
                end else if (short_offset || set1_hit_idx) begin
                    illegal_nxt = 1'b1;
                end else begin
                    eff_addr_nxt = {oag_pkg::OAG_ZERO_BYTE, idx_reg_addr};
                    space_nxt = oag_pkg::OAG_SPACE_REGFILE;
                end
            end
            oag_pkg::OAG_MODE_DIRECT: begin
                eff_addr_nxt = operand_field;
                if (mem_load) begin
                    space_nxt = mem_space_ext ? oag_pkg::OAG_SPACE_EXTMEM
                                              : oag_pkg::OAG_SPACE_PROGMEM;
                end else if (instr_class == oag_pkg::OAG_CLS_JUMP ||
                             instr_class == oag_pkg::OAG_CLS_CALL) begin
                    space_nxt = oag_pkg::OAG_SPACE_PROGMEM;
                    pc_load_nxt = 1'b1;
                end else begin
                    illegal_nxt = 1'b1;
                end
            end
            oag_pkg::OAG_MODE_IND_ADDR: begin
                if (instr_class == oag_pkg::OAG_CLS_CALL) begin
                    eff_addr_nxt = vec_addr;
                    space_nxt = oag_pkg::OAG_SPACE_PROGMEM;
                    vector_fetch_nxt = 1'b1;
                end else begin
                    illegal_nxt = 1'b1;
                end
            end
            oag_pkg::OAG_MODE_RELATIVE: begin
                if (instr_class == oag_pkg::OAG_CLS_REL_BRANCH) begin
                    eff_addr_nxt = rel_target;
                    space_nxt = oag_pkg::OAG_SPACE_PROGMEM;
                    pc_load_nxt = 1'b1;
                end else begin
                    illegal_nxt = 1'b1;
                end
            end
            oag_pkg::OAG_MODE_IMMEDIATE: begin
                operand_nxt = word_operand ? operand_field
                                           : {oag_pkg::OAG_ZERO_BYTE, operand_field[7:0]};
                operand_valid_nxt = 1'b1;
            end
            default: begin
                // Stack access; address depends on push or pop
                space_nxt = oag_pkg::OAG_SPACE_REGFILE;
                if (push_req) begin
                    eff_addr_nxt = {oag_pkg::OAG_ZERO_BYTE, sp_dec};
                end else begin
                    eff_addr_nxt = {oag_pkg::OAG_ZERO_BYTE, stack_pointer_low_byte};
                end
            end
        endcase
    end

    // ==========================================================
    // Result registers, loaded once per accepted request
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_addr_r <= oag_pkg::OAG_ZERO_BYTE;
            eff_addr_r <= oag_pkg::OAG_ZERO_WORD;
            space_r <= oag_pkg::OAG_SPACE_NONE;
            operand_r <= oag_pkg::OAG_ZERO_WORD;
            operand_valid_r <= 1'b0;
            pc_load_r <= 1'b0;
            vector_fetch_r <= 1'b0;
            illegal_r <= 1'b0;
            done_r <= 1'b0;
        end else if (clk_en) begin
            done_r <= req_valid;
            if (req_valid) begin
                reg_addr_r <= reg_addr_nxt;
                eff_addr_r <= eff_addr_nxt;
                space_r <= space_nxt;
                operand_r <= operand_nxt;
                operand_valid_r <= operand_valid_nxt;
                pc_load_r <= pc_load_nxt;
                vector_fetch_r <= vector_fetch_nxt;
                illegal_r <= illegal_nxt;
            end
        end
    end

    // ==========================================================
    // Stack pointer: pre-decrement on push, post-increment on pop
    // Starts at FF so early pushes cannot wrap into the high byte
    logic do_push;
    logic do_pop;
    assign do_push = req_valid && (mode == oag_pkg::OAG_MODE_STACK) && push_req;
    assign do_pop = req_valid && (mode == oag_pkg::OAG_MODE_STACK) && !push_req && pop_req;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stack_pointer_low_byte <= oag_pkg::OAG_SP_RESET;
            stack_addr_r <= oag_pkg::OAG_SP_RESET;
        end else if (clk_en) begin
            if (do_push) begin
                stack_pointer_low_byte <= sp_dec;
                stack_addr_r <= sp_dec;
            end else if (do_pop) begin
                stack_pointer_low_byte <= sp_inc;
                stack_addr_r <= stack_pointer_low_byte;
            end
        end
    end

endmodule

// >>> tb/oag_props.sv
`timescale 1ns/100ps
// ==========================================================
// Port-level timing and address checks
module oag_props (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic req_valid,
    input wire oag_pkg::oag_mode_e mode,
    input wire oag_pkg::oag_class_e instr_class,
    input wire logic [15:0] operand_field,
    input wire logic [15:0] pc_next,
    input wire logic [15:0] reg_value,
    input wire logic push_req,
    input wire logic pop_req,
    input wire logic [15:0] eff_addr_r,
    input wire oag_pkg::oag_space_e space_r,
    input wire logic pc_load_r,
    input wire logic vector_fetch_r,
    input wire logic illegal_r,
    input wire logic done_r,
    input wire logic [7:0] stack_pointer_low_byte,
    input wire logic [7:0] stack_addr_r
);
    // Targets as plain nets, so past values need no expressions
    wire take = req_valid && clk_en;
    wire [15:0] rel_sum = pc_next + {{8{operand_field[7]}}, operand_field[7:0]};
    wire [15:0] vec_addr = {8'h00, operand_field[7:0]};
    wire ia_req = take && mode == oag_pkg::OAG_MODE_IND_ADDR;
    wire stk = take && mode == oag_pkg::OAG_MODE_STACK;
    wire [7:0] sp = stack_pointer_low_byte;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    chk_done_pulse: assert property (take |=> done_r)
        else $error("done missing after request");
    chk_done_idle: assert property (!req_valid && clk_en |=> !done_r)
        else $error("done without request");
    chk_vector_low: assert property (ia_req && instr_class == oag_pkg::OAG_CLS_CALL
        |=> vector_fetch_r && eff_addr_r == $past(vec_addr)) else $error("vector address wrong");
    chk_vector_call: assert property (ia_req && instr_class != oag_pkg::OAG_CLS_CALL
        |=> illegal_r && !vector_fetch_r) else $error("vector fetch outside call");
    chk_rel_target: assert property (take && mode == oag_pkg::OAG_MODE_RELATIVE &&
        instr_class == oag_pkg::OAG_CLS_REL_BRANCH
        |=> pc_load_r && eff_addr_r == $past(rel_sum)) else $error("relative target wrong");
    chk_direct_pc: assert property (take && mode == oag_pkg::OAG_MODE_DIRECT &&
        instr_class == oag_pkg::OAG_CLS_JUMP |=> pc_load_r && eff_addr_r == $past(operand_field))
        else $error("direct jump target wrong");
    chk_set1_refused: assert property (take && mode == oag_pkg::OAG_MODE_IND_REG &&
        instr_class == oag_pkg::OAG_CLS_GENERAL_LOAD && reg_value[7:6] == 2'h3
        |=> illegal_r && space_r == oag_pkg::OAG_SPACE_NONE) else $error("set-1 reached");
    chk_push_predec: assert property (stk && push_req
        |=> sp == $past(sp) - 8'h01 && stack_addr_r == sp) else $error("push address wrong");
    chk_pop_postinc: assert property (stk && pop_req && !push_req
        |=> stack_addr_r == $past(sp) && sp == $past(sp) + 8'h01) else $error("pop address wrong");
    cover property (stk && push_req);
    cover property (stk && pop_req && !push_req);
    cover property (take && mode == oag_pkg::OAG_MODE_RELATIVE);
    cover property ($rose(illegal_r));
endmodule
bind oag_top oag_props u_props (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .req_valid(req_valid), .mode(mode), .instr_class(instr_class),
    .operand_field(operand_field), .pc_next(pc_next), .reg_value(reg_value),
    .push_req(push_req), .pop_req(pop_req), .eff_addr_r(eff_addr_r), .space_r(space_r),
    .pc_load_r(pc_load_r), .vector_fetch_r(vector_fetch_r), .illegal_r(illegal_r),
    .done_r(done_r), .stack_pointer_low_byte(stack_pointer_low_byte),
    .stack_addr_r(stack_addr_r));

// >>> tb/tb_operand_address_generator.sv
`timescale 1ns/100ps
// ==========================================================
// Table-driven bench, then stack, freeze and reset cases
module tb_operand_address_generator;
    typedef struct packed {logic [2:0] m; logic [2:0] c; logic o; logic [15:0] f;
        logic [15:0] v; logic [15:0] e; logic [1:0] s; logic [2:0] fl;} oag_row_s;
    localparam logic [2:0] M_IND = oag_pkg::OAG_MODE_IND_REG, M_IDX = oag_pkg::OAG_MODE_INDEXED,
        M_DIR = oag_pkg::OAG_MODE_DIRECT, M_VEC = oag_pkg::OAG_MODE_IND_ADDR,
        M_REL = oag_pkg::OAG_MODE_RELATIVE, M_REG = oag_pkg::OAG_MODE_REG,
        M_IMM = oag_pkg::OAG_MODE_IMMEDIATE;
    localparam logic [2:0] C_GL = oag_pkg::OAG_CLS_GENERAL_LOAD, C_OT = oag_pkg::OAG_CLS_OTHER,
        C_PL = oag_pkg::OAG_CLS_PROGMEM_LOAD, C_EL = oag_pkg::OAG_CLS_EXTDATA_LOAD,
        C_CA = oag_pkg::OAG_CLS_CALL, C_JU = oag_pkg::OAG_CLS_JUMP, C_RB = oag_pkg::OAG_CLS_REL_BRANCH;
    localparam logic [1:0] S_RF = oag_pkg::OAG_SPACE_REGFILE, S_PM = oag_pkg::OAG_SPACE_PROGMEM,
        S_EM = oag_pkg::OAG_SPACE_EXTMEM, S_NO = oag_pkg::OAG_SPACE_NONE;
    // Flags column is {illegal, pc_load, vector_fetch}
    oag_row_s rows [0:14] = '{
        '{M_IND, C_GL, 1'b0, 16'h0000, 16'h0045, 16'h0045, S_RF, 3'h0},
        '{M_IND, C_GL, 1'b0, 16'h0000, 16'h00c5, 16'h0000, S_NO, 3'h4},
        '{M_IND, C_PL, 1'b0, 16'h0000, 16'h12c5, 16'h12c5, S_PM, 3'h0},
        '{M_IDX, C_GL, 1'b0, 16'h0080, 16'h003f, 16'h00bf, S_RF, 3'h0},
        '{M_IDX, C_GL, 1'b0, 16'h0080, 16'h0040, 16'h0000, S_NO, 3'h4},
        '{M_IDX, C_EL, 1'b1, 16'h0080, 16'h2000, 16'h1f80, S_EM, 3'h0},
        '{M_IDX, C_PL, 1'b0, 16'h0180, 16'h2000, 16'h2180, S_PM, 3'h0},
        '{M_DIR, C_JU, 1'b0, 16'hbeef, 16'h0000, 16'hbeef, S_PM, 3'h2},
        '{M_DIR, C_EL, 1'b0, 16'h4321, 16'h0000, 16'h4321, S_EM, 3'h0},
        '{M_VEC, C_CA, 1'b0, 16'hff7a, 16'h0000, 16'h007a, S_PM, 3'h1},
        '{M_VEC, C_JU, 1'b0, 16'h007a, 16'h0000, 16'h0000, S_NO, 3'h4},
        '{M_REL, C_RB, 1'b0, 16'h0080, 16'h0000, 16'h0f80, S_PM, 3'h2},
        '{M_REG, C_GL, 1'b1, 16'h00cb, 16'h1234, 16'h1234, S_RF, 3'h0},
        '{M_REG, C_GL, 1'b0, 16'h00c6, 16'h1234, 16'h0034, S_RF, 3'h0},
        '{M_IMM, C_OT, 1'b0, 16'habcd, 16'h0000, 16'h00cd, S_NO, 3'h0}};
    logic core_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, req_valid = 1'b0;
    logic pair_sel = 1'b0, short_offset = 1'b0, word_operand = 1'b0;
    logic push_req = 1'b0, pop_req = 1'b0, operand_valid_r, pc_load_r, vector_fetch_r;
    logic illegal_r, done_r;
    oag_pkg::oag_mode_e mode = oag_pkg::OAG_MODE_REG;
    oag_pkg::oag_class_e instr_class = oag_pkg::OAG_CLS_OTHER;
    oag_pkg::oag_space_e space_r;
    logic [7:0] reg_field = 8'h00, reg_addr_r, stack_pointer_low_byte, stack_addr_r, sp_m;
    logic [15:0] operand_field = 16'h0000, reg_value = 16'h0000, eff_addr_r, operand_r;
    int err_count = 0, n_checks = 0;
    oag_top dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .req_valid(req_valid),
        .mode(mode), .instr_class(instr_class), .reg_field(reg_field), .pair_sel(pair_sel),
        .short_offset(short_offset), .word_operand(word_operand), .operand_field(operand_field),
        .pc_next(16'h1000), .reg_value(reg_value), .push_req(push_req), .pop_req(pop_req),
        .first_window_pointer(8'h70), .second_window_pointer(8'ha8), .page_select_reg(8'h00),
        .reg_addr_r(reg_addr_r), .eff_addr_r(eff_addr_r), .space_r(space_r),
        .operand_r(operand_r), .operand_valid_r(operand_valid_r), .pc_load_r(pc_load_r),
        .vector_fetch_r(vector_fetch_r), .illegal_r(illegal_r), .done_r(done_r),
        .stack_pointer_low_byte(stack_pointer_low_byte), .stack_addr_r(stack_addr_r));
    // 25 MHz core clock
    always #20 core_clk = ~core_clk;
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Window pointers are fixed at 70 and a8 above
    task automatic check_row(input oag_row_s p);
        logic [7:0] win;
        win = p.f[3] ? 8'ha8 : 8'h70;
        chk("done", done_r, 16'h0001);
        if (p.m == M_REG || p.m == M_IMM) begin
            chk("operand", operand_r, p.e);
            chk("operand_valid", operand_valid_r, 16'h0001);
        end else begin
            chk("eff_addr", eff_addr_r, p.e);
            chk("space", space_r, p.s);
            chk("flags", {illegal_r, pc_load_r, vector_fetch_r}, p.fl);
        end
        if (p.m == M_REG) chk("reg_addr", reg_addr_r, {win[7:3], p.f[2:0]});
    endtask
    // Reset drops req_valid and push_req so none is taken while it is held
    task automatic do_reset();
        @(posedge core_clk);
        rst_n <= 1'b0;
        req_valid <= 1'b0;
        push_req <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1 chk("rst_space", space_r, S_NO);
        chk("rst_sp", stack_pointer_low_byte, 8'hff);
        chk("rst_done", done_r, 1'b0);
        @(posedge core_clk);
        rst_n <= 1'b1;
    endtask
    // Hang guard well beyond the real run length
    initial begin
        repeat (3000) @(posedge core_clk);
        err_count++;
        complete_run();
    end
    // Rows go back to back; each row is checked just after the edge that takes it
    initial begin
        do_reset();
        for (int i = 0; i <= 15; i++) begin
            @(posedge core_clk);
            req_valid <= (i < 15);
            if (i < 15) begin
                mode <= oag_pkg::oag_mode_e'(rows[i].m);
                instr_class <= oag_pkg::oag_class_e'(rows[i].c);
                {pair_sel, short_offset, word_operand} <= {3{rows[i].o}};
                operand_field <= rows[i].f;
                reg_field <= rows[i].f[7:0];
                reg_value <= rows[i].v;
            end
            #1 if (i > 0) check_row(rows[i-1]);
        end
        // Four pushes then four pops, first push with pop also high
        sp_m = 8'hff;
        for (int j = 0; j <= 8; j++) begin
            @(posedge core_clk);
            mode <= oag_pkg::OAG_MODE_STACK;
            req_valid <= (j < 8);
            push_req <= (j < 4);
            pop_req <= (j == 0) || (j >= 4 && j < 8);
            #1 if (j > 0) begin
                if (j <= 4) sp_m = sp_m - 8'h01;
                chk("stack_addr", stack_addr_r, sp_m);
                if (j > 4) sp_m = sp_m + 8'h01;
                chk("sp", stack_pointer_low_byte, sp_m);
            end
        end
        // Request held while the clock enable is low must not move the stack
        @(posedge core_clk);
        clk_en <= 1'b0;
        req_valid <= 1'b1;
        push_req <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1 chk("frozen_sp", stack_pointer_low_byte, 8'hff);
        @(posedge core_clk);
        clk_en <= 1'b1;
        @(posedge core_clk);
        #1 chk("push_after_freeze", stack_pointer_low_byte, 8'hfe);
        do_reset();
        complete_run();
    end
endmodule
